/* File: logic/lbirq_aggregator.sv */
/*
 * per-link interrupt aggregator: master enable, tc overflow enable,
 * sixteen status and enable registers, master status and the irq pin.
 * assumes a simple synchronous host port (addr, wr_en, rd_en) at 40 MHz.
 */
`timescale 1ns/1ps
module lbirq_aggregator
    import lbirq_pkg::*;
(
    // clock and reset
    input  wire logic                                         clock,
    input  wire logic                                         srst,
    // host register port
    input  wire logic [lbirq_pkg::ADDR_W-1:0]                 addr,
    input  wire logic [lbirq_pkg::DATA_W-1:0]                 wdata,
    input  wire logic                                         wr_en,
    input  wire logic                                         rd_en,
    output logic      [lbirq_pkg::DATA_W-1:0]                 rdata_r,
    // per-link condition levels and event pulses
    input  wire logic [lbirq_pkg::NUM_LINKS-1:0]              delay_sync_loss,
    input  wire logic [lbirq_pkg::NUM_LINKS-1:0]              frame_loss,
    input  wire logic [lbirq_pkg::NUM_LINKS-1:0]              cell_delineation_loss,
    input  wire logic [lbirq_pkg::NUM_LINKS-1:0]              icp_ram_ovf,
    input  wire logic [lbirq_pkg::NUM_LINKS-1:0]              icp_change,
    input  wire logic [lbirq_pkg::NUM_LINKS*lbirq_pkg::LOW_W-1:0] low_status,
    input  wire logic [lbirq_pkg::NUM_LINKS-1:0]              tc_ovf_status,
    // device-wide sources for link 0
    input  wire logic [lbirq_pkg::NUM_GROUPS-1:0]             group_ovf_req,
    input  wire logic                                         txrdy_fp_evt,
    // interrupt pin and master status view
    output logic                                              irq_n_r,
    output logic      [lbirq_pkg::NUM_LINKS-1:0]              master_stat_r
);
    logic [15:0] master_en_r;
    logic [15:0] master_en_nxt;
    logic [15:0] tc_en_r;
    logic [15:0] tc_en_nxt;
    logic [11:0] link_en_r   [NUM_LINKS];
    logic [11:0] link_en_nxt [NUM_LINKS];
    logic [15:0] link_status [NUM_LINKS];
    logic [15:0] master_stat;
    logic [15:0] rdata_nxt;
    logic        irq_n_nxt;

    // one status register per link
    for (genvar i = 0; i < NUM_LINKS; i++) begin : g_link
        lbirq_link_status #(.LINK_IDX(i)) u_stat (
            .clock                 (clock),
            .srst                  (srst),
            .wr_hit                (wr_en && addr == OFS_STATUS_BASE + 12'(i)),
            .wdata                 (wdata),
            .delay_sync_loss       (delay_sync_loss[i]),
            .frame_loss            (frame_loss[i]),
            .cell_delineation_loss (cell_delineation_loss[i]),
            .icp_ram_ovf           (icp_ram_ovf[i]),
            .icp_change            (icp_change[i]),
            .group_ovf_any         (|group_ovf_req),
            .txrdy_fp_evt          (txrdy_fp_evt),
            .low_bits              (low_status[i*LOW_W +: LOW_W]),
            .status                (link_status[i])
        );
        // link request: enabled status bits plus gated tc overflow
        assign master_stat[i] = |(link_status[i][11:0] & link_en_r[i])
                              | (tc_ovf_status[i] & tc_en_r[i]);
    end

    // register writes; master status has no write path
    always_comb begin
        master_en_nxt = master_en_r;
        tc_en_nxt     = tc_en_r;
        for (int k = 0; k < NUM_LINKS; k++) begin
            link_en_nxt[k] = link_en_r[k];
            if (wr_en && addr == OFS_ENABLE_BASE + 12'(k)) begin
                link_en_nxt[k] = wdata[11:0];
            end
        end
        if (wr_en && addr == OFS_MASTER_EN) begin
            master_en_nxt = wdata;
        end
        if (wr_en && addr == OFS_TC_EN) begin
            tc_en_nxt = wdata;
        end
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        rdata_nxt = rdata_r;
        if (rd_en) begin
            rdata_nxt = 16'h0000;
            if (addr == OFS_MASTER_EN) rdata_nxt = master_en_r;
            if (addr == OFS_TC_EN) rdata_nxt = tc_en_r;
            if (addr == OFS_MASTER_STAT) rdata_nxt = master_stat;
            for (int k = 0; k < NUM_LINKS; k++) begin
                if (addr == OFS_STATUS_BASE + 12'(k)) rdata_nxt = link_status[k];
                if (addr == OFS_ENABLE_BASE + 12'(k)) rdata_nxt = {4'h0, link_en_r[k]};
            end
        end
    end

    // pin follows live master status and enables each cycle
    always_comb begin
        irq_n_nxt = !(|(master_stat & master_en_r));
    end

    // register enables, read data, pin and the master status copy
    always_ff @(posedge clock) begin
        if (srst) begin
            master_en_r   <= MASTER_EN_RST;
            tc_en_r       <= TC_EN_RST;
            rdata_r       <= 16'h0000;
            irq_n_r       <= 1'b1;
            master_stat_r <= 16'h0000;
            for (int k = 0; k < NUM_LINKS; k++) link_en_r[k] <= LINK_EN_RST;
        end else begin
            master_en_r   <= master_en_nxt;
            tc_en_r       <= tc_en_nxt;
            rdata_r       <= rdata_nxt;
            irq_n_r       <= irq_n_nxt;
            master_stat_r <= master_stat;
            for (int k = 0; k < NUM_LINKS; k++) link_en_r[k] <= link_en_nxt[k];
        end
    end

    a_pin_asserts: assert property (@(posedge clock) disable iff (srst)
        (|(master_stat & master_en_r)) |=> !irq_n_r)
        else $error("irq pin not low for enabled pending link");
    a_pin_masked: assert property (@(posedge clock) disable iff (srst)
        (!(|(master_stat & master_en_r))) |=> irq_n_r)
        else $error("irq pin low with no enabled request");
    a_tc_gate_off: assert property (@(posedge clock) disable iff (srst)
        (!tc_en_r[5] && link_en_r[5] == 12'h000) |-> !master_stat[5])
        else $error("tc overflow raised request while disabled");
    a_top_nibble_zero: assert property (@(posedge clock) disable iff (srst)
        link_status[5][15:12] == 4'h0)
        else $error("status top bits not zero");
    a_delay_sync_loss_end_sets: assert property (@(posedge clock) disable iff (srst)
        (!$past(srst) && $fell(delay_sync_loss[3])) |=> link_status[3][BIT_DELAY_SYNC_LOSS_END])
        else $error("sync loss end flag not set");
    a_grp_only_link0: assert property (@(posedge clock) disable iff (srst)
        !link_status[1][BIT_GRP_OVF] && (link_status[0][BIT_GRP_OVF] == (|group_ovf_req)))
        else $error("group summary bit wrong");
    a_txrdy_only_link0: assert property (@(posedge clock) disable iff (srst)
        txrdy_fp_evt |=> link_status[0][BIT_TXRDY_FP] && !link_status[2][BIT_TXRDY_FP])
        else $error("tx ready flag placement wrong");
    a_ram_ovf_sticky: assert property (@(posedge clock) disable iff (srst)
        (icp_ram_ovf[2] ##1 !(wr_en && addr == OFS_STATUS_BASE + 12'h002))
        |=> link_status[2][BIT_ICP_RAM_OVF])
        else $error("ram overflow flag lost");
    a_mstat_read: assert property (@(posedge clock) disable iff (srst)
        (rd_en && addr == OFS_MASTER_STAT) |=> rdata_r == $past(master_stat))
        else $error("master status read mismatch");

    // write paths of the enable registers; master status has none
    a_master_en_write: assert property (@(posedge clock) disable iff (srst)
        (wr_en && addr == OFS_MASTER_EN) |=> master_en_r == $past(wdata))
        else $error("master enable write lost");
    a_tc_en_write: assert property (@(posedge clock) disable iff (srst)
        (wr_en && addr == OFS_TC_EN) |=> tc_en_r == $past(wdata))
        else $error("tc enable write lost");
    a_link_en_write: assert property (@(posedge clock) disable iff (srst)
        (wr_en && addr == OFS_ENABLE_BASE + 12'h002) |=> link_en_r[2] == $past(wdata[11:0]))
        else $error("link enable write lost");
    a_mstat_wr_ignored: assert property (@(posedge clock) disable iff (srst)
        (wr_en && addr == OFS_MASTER_STAT) |=> $stable(master_en_r) && $stable(tc_en_r))
        else $error("master status write disturbed enables");
    a_en_top_zero: assert property (@(posedge clock) disable iff (srst)
        (rd_en && addr == OFS_ENABLE_BASE + 12'h002) |=> rdata_r[15:12] == 4'h0)
        else $error("enable top bits not zero");

    // sticky flag set and clear paths on the links the bench drives
    a_lif_end_sets: assert property (@(posedge clock) disable iff (srst)
        (!$past(srst) && $fell(frame_loss[3])) |=> link_status[3][BIT_LIF_END])
        else $error("frame loss end flag not set");
    a_lcd_end_sets: assert property (@(posedge clock) disable iff (srst)
        (!$past(srst) && $fell(cell_delineation_loss[3])) |=> link_status[3][BIT_LCD_END])
        else $error("cell delineation end flag not set");
    a_change_sets: assert property (@(posedge clock) disable iff (srst)
        icp_change[3] |=> link_status[3][BIT_ICP_CHANGE])
        else $error("icp change flag not set");
    a_flags_cleared: assert property (@(posedge clock) disable iff (srst)
        (wr_en && addr == OFS_STATUS_BASE + 12'h003 && wdata == 16'h0000
            && !icp_ram_ovf[3] && !icp_change[3]
            && $stable({delay_sync_loss[3], frame_loss[3], cell_delineation_loss[3]}))
        |=> link_status[3][11:9] == 3'h0 && link_status[3][6:5] == 2'h0)
        else $error("written zero did not clear flags");
    a_txrdy_cleared: assert property (@(posedge clock) disable iff (srst)
        (wr_en && addr == OFS_STATUS_BASE && !wdata[BIT_TXRDY_FP] && !txrdy_fp_evt)
        |=> !link_status[0][BIT_TXRDY_FP])
        else $error("tx ready flag not cleared");

    // link 0 only bits never show on other links
    a_other_links_zero: assert property (@(posedge clock) disable iff (srst)
        !link_status[7][BIT_GRP_OVF] && !link_status[7][BIT_TXRDY_FP])
        else $error("link 0 only bit seen on link 7");

    // request forming and pin masking
    a_tc_gate_on: assert property (@(posedge clock) disable iff (srst)
        (tc_ovf_status[5] && tc_en_r[5]) |-> master_stat[5])
        else $error("enabled tc overflow raised no request");
    a_en_gates_req: assert property (@(posedge clock) disable iff (srst)
        (link_status[2][BIT_ICP_RAM_OVF] && link_en_r[2][BIT_ICP_RAM_OVF]) |-> master_stat[2])
        else $error("enabled status bit raised no request");
    a_req_needs_en: assert property (@(posedge clock) disable iff (srst)
        (link_en_r[2] == 12'h000 && !tc_en_r[2]) |-> !master_stat[2])
        else $error("request raised with all enables clear");
    a_pin_released: assert property (@(posedge clock) disable iff (srst)
        (master_en_r == 16'h0000) |=> irq_n_r)
        else $error("irq pin low with master enables clear");
endmodule : lbirq_aggregator

/* File: logic/lbirq_pkg.sv */
/*
 * constants for the per-link interrupt aggregator: register offsets,
 * status bit positions, field masks and reset values.
 * assumes a 16-bit host data path with word-indexed register offsets.
 */
package lbirq_pkg;
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 16;
    localparam int          NUM_LINKS       = 16;
    localparam int          NUM_GROUPS      = 8;
    localparam int          LOW_W           = 5;
    // register offsets, as word indices on the host port
    localparam logic [11:0] OFS_MASTER_EN   = 12'h433;
    localparam logic [11:0] OFS_TC_EN       = 12'h434;
    localparam logic [11:0] OFS_STATUS_BASE = 12'h435;
    localparam logic [11:0] OFS_ENABLE_BASE = 12'h445;
    localparam logic [11:0] OFS_MASTER_STAT = 12'h455;
    // status bit positions
    localparam int          BIT_DELAY_SYNC_LOSS_END    = 11;
    localparam int          BIT_LIF_END     = 10;
    localparam int          BIT_LCD_END     = 9;
    localparam int          BIT_GRP_OVF     = 8;
    localparam int          BIT_TXRDY_FP    = 7;
    localparam int          BIT_ICP_RAM_OVF = 6;
    localparam int          BIT_ICP_CHANGE  = 5;
    // masks and reset values
    localparam logic [15:0] USED_MASK       = 16'h0fff;
    localparam logic [15:0] MASTER_EN_RST   = 16'h0000;
    localparam logic [15:0] TC_EN_RST       = 16'h0000;
    localparam logic [15:0] STATUS_RST      = 16'h0000;
    localparam logic [11:0] LINK_EN_RST     = 12'h000;
endpackage : lbirq_pkg

/* File: logic/lbirq_link_status.sv */
/*
 * one link's interrupt status register: sticky flags in bits 11:9 and 7:5,
 * group summary in bit 8, live lower bits 4:0 from their own sources.
 * assumes event inputs are synchronous to clock; set wins over a clear.
 */
`timescale 1ns/1ps
module lbirq_link_status
    import lbirq_pkg::*;
#(
    parameter int LINK_IDX = 0
) (
    // clock and reset
    input  wire logic                      clock,
    input  wire logic                      srst,
    // host write to this link's status register
    input  wire logic                      wr_hit,
    input  wire logic [lbirq_pkg::DATA_W-1:0] wdata,
    // condition levels and event pulses
    input  wire logic                      delay_sync_loss,
    input  wire logic                      frame_loss,
    input  wire logic                      cell_delineation_loss,
    input  wire logic                      icp_ram_ovf,
    input  wire logic                      icp_change,
    input  wire logic                      group_ovf_any,
    input  wire logic                      txrdy_fp_evt,
    input  wire logic [lbirq_pkg::LOW_W-1:0]  low_bits,
    // assembled register value
    output logic      [lbirq_pkg::DATA_W-1:0] status
);
    logic [15:0] flags_r;
    logic [15:0] flags_nxt;
    logic [2:0]  cond_r;
    logic [2:0]  cond_nxt;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;

    // sticky flags: set on event, cleared by a written zero, set wins
    always_comb begin
        cond_nxt = {delay_sync_loss, frame_loss, cell_delineation_loss};
        set_vec  = 16'h0000;
        set_vec[BIT_DELAY_SYNC_LOSS_END] = cond_r[2] && !delay_sync_loss;
        set_vec[BIT_LIF_END]  = cond_r[1] && !frame_loss;
        set_vec[BIT_LCD_END]  = cond_r[0] && !cell_delineation_loss;
        set_vec[BIT_TXRDY_FP] = (LINK_IDX == 0) && txrdy_fp_evt;
        set_vec[BIT_ICP_RAM_OVF] = icp_ram_ovf;
        set_vec[BIT_ICP_CHANGE]  = icp_change;
        clr_vec   = wr_hit ? ~wdata : 16'h0000;
        flags_nxt = ((flags_r & ~clr_vec) | set_vec) & 16'h0ee0;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            flags_r <= STATUS_RST;
            cond_r  <= 3'h0;
        end else begin
            flags_r <= flags_nxt;
            cond_r  <= cond_nxt;
        end
    end

    // summary bit only exists for link 0, top nibble always zero
    always_comb begin
        status = (flags_r | {11'h000, low_bits}) & USED_MASK;
        status[BIT_GRP_OVF] = (LINK_IDX == 0) && group_ovf_any;
    end
endmodule : lbirq_link_status

/* File: bench/lbirq_host_irq_mon.sv */
/*
 * host-side model of the interrupt input: counts cycles the pin is low.
 * assumes the pin is the active-low level driven by the aggregator.
 */
`timescale 1ns/1ps
module lbirq_host_irq_mon (
    // clock and pin
    input  wire logic        clock,
    input  wire logic        irq_n,
    // cycles seen with a pending interrupt
    output logic      [15:0] low_cnt
);
    // the host only observes; the receive link clock is not modelled
    initial low_cnt = 16'h0000;
    always @(posedge clock) if (irq_n === 1'b0) low_cnt <= low_cnt + 16'h0001;
endmodule : lbirq_host_irq_mon

/* File: bench/tb_top.sv */
/*
 * self-checking bench for the per-link interrupt aggregator.
 * assumes the strobe host port and one-cycle latencies of the design.
 */
`timescale 1ns/1ps
module tb_top;
    import lbirq_pkg::*;
    logic clock = 1'b0, srst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, txrdy_fp_evt = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [15:0] wdata = 16'h0000, rdata_r, master_stat_r, low_cnt;
    logic [15:0] dsl = 16'h0000, fl = 16'h0000, cdl = 16'h0000, ovf = 16'h0000;
    logic [15:0] chg = 16'h0000, tc = 16'h0000;
    logic [79:0] low_status = 80'h0;
    logic [7:0]  grp = 8'h00;
    logic        irq_n_r;
    int          fail_count = 0, checks_done = 0, cyc = 0;
    // clock source and hang guard
    initial forever #12.5 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            wrap_up();
        end
    end
    lbirq_aggregator dut_u (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata_r(rdata_r), .delay_sync_loss(dsl),
        .frame_loss(fl), .cell_delineation_loss(cdl), .icp_ram_ovf(ovf), .icp_change(chg),
        .low_status(low_status), .tc_ovf_status(tc), .group_ovf_req(grp),
        .txrdy_fp_evt(txrdy_fp_evt), .irq_n_r(irq_n_r), .master_stat_r(master_stat_r));
    lbirq_host_irq_mon host_u (.clock(clock), .irq_n(irq_n_r), .low_cnt(low_cnt));
    // bus cycles, timing and comparison
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        tick(1);
        wr_en = 1'b0;
        tick(1);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [15:0] exp, input string what);
        addr = a;
        rd_en = 1'b1;
        tick(1);
        rd_en = 1'b0;
        chk(what, exp, rdata_r);
        tick(1);
    endtask : rd
    task automatic irq(input logic exp);
        chk("irq pin", {15'h0, exp}, {15'h0, irq_n_r});
    endtask : irq
    task automatic wrap_up();
        if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    // reset values, unmapped read, live lower bits
    task automatic s_reset();
        rd(12'h433, 16'h0000, "master enable");
        rd(12'h434, 16'h0000, "tc enable");
        rd(12'h435, 16'h0000, "status 0");
        rd(12'h445, 16'h0000, "enable 0");
        rd(12'h455, 16'h0000, "master status");
        rd(12'h456, 16'h0000, "unmapped");
        rd(12'h439, 16'h0015, "status 4 low bits");
        irq(1'b1);
    endtask : s_reset
    // sticky flags of link 3, write-one keeps, write-zero clears
    task automatic s_flags();
        dsl[3] = 1'b1; fl[3] = 1'b1; cdl[3] = 1'b1;
        tick(2);
        dsl[3] = 1'b0; fl[3] = 1'b0; cdl[3] = 1'b0; ovf[3] = 1'b1; chg[3] = 1'b1;
        tick(1);
        ovf[3] = 1'b0; chg[3] = 1'b0;
        tick(2);
        rd(12'h438, 16'h0e60, "status 3 flags");
        wr(12'h438, 16'hffff);
        rd(12'h438, 16'h0e60, "status 3 upper");
        wr(12'h438, 16'h0000);
        rd(12'h438, 16'h0000, "status 3 cleared");
    endtask : s_flags
    // link 0 only bits: group summary and tx ready or frame pulse
    task automatic s_link0();
        grp = 8'h04; txrdy_fp_evt = 1'b1;
        tick(1);
        txrdy_fp_evt = 1'b0;
        tick(2);
        rd(12'h435, 16'h0180, "status 0 summary");
        rd(12'h436, 16'h0000, "status 1 summary");
        wr(12'h435, 16'h0000);
        rd(12'h435, 16'h0100, "status 0 after clear");
        grp = 8'h00;
        tick(2);
        rd(12'h435, 16'h0000, "status 0 serviced");
    endtask : s_link0
    // request path, masking and master status
    task automatic s_irq();
        wr(12'h433, 16'h0004);
        wr(12'h447, 16'h0040);
        ovf[2] = 1'b1;
        tick(1);
        ovf[2] = 1'b0;
        tick(3);
        irq(1'b0);
        chk("master status reg", 16'h0004, master_stat_r);
        rd(12'h455, 16'h0004, "master status");
        wr(12'h455, 16'h0000);
        rd(12'h455, 16'h0004, "master status write");
        wr(12'h433, 16'h0000);
        tick(2);
        irq(1'b1);
        wr(12'h433, 16'h0004);
        wr(12'h447, 16'h0020);
        tick(3);
        irq(1'b1);
        wr(12'h447, 16'hffff);
        rd(12'h447, 16'h0fff, "enable 2");
        tick(2);
        irq(1'b0);
        wr(12'h437, 16'h0000);
        tick(3);
        irq(1'b1);
        chk("host low count", 16'h0001, {15'h0, low_cnt != 16'h0000});
    endtask : s_irq
    // tc overflow request gated by its enable
    task automatic s_tc();
        tc[5] = 1'b1;
        wr(12'h433, 16'h0020);
        tick(3);
        irq(1'b1);
        wr(12'h434, 16'hffff);
        tick(3);
        irq(1'b0);
        chk("master status reg", 16'h0020, master_stat_r);
        rd(12'h434, 16'hffff, "tc enable");
        wr(12'h434, 16'h0000);
        tick(3);
        irq(1'b1);
    endtask : s_tc
    initial begin
        low_status[24:20] = 5'h15;
        tick(16);
        srst = 1'b0;
        tick(1);
        s_reset();
        s_flags();
        s_link0();
        s_irq();
        s_tc();
        wrap_up();
    end
endmodule : tb_top
